// file: rtl/output_terminal_routing_params.svh
/*
  Constants for the output terminal router: register offsets, reset values,
  field layout and timing counts.
  Assumes a 25 MHz core clock and a 32-bit APB register bus.

// What this block does
// [RL1] Terminal 11 drives its selected status; default code 01, speed reached.
// [RL2] Terminal 12 drives its selected status; default code 00, running.
// [RL3] Terminal 13 drives its selected status; default code 03, overload warning.
// [RL4] Terminal 14 drives its selected status; default code 07, excess torque.
// [RL5] Relay defaults to code 05, fault; terminal 15 to code 08, power loss.
// [RL6] Three analog meters pick one of 12 sources; every default is 00.
// [RL7] Fault code output overrides terminals 11-13 or 11-14 with code bits.
// [RL8] Polarity 00 is normally open, 01 normally closed and inverts the sense.
// [RL9] Terminals 11-15 reset to polarity 00, normally open, active low.
// [RL10] Relay polarity is invertible too and resets to 01, normally closed.
// [RL11] Current pulse runs at 1.44 kHz; full scale 0.20 to 2.00, default 1.0.
// [RL12] Each level is the selected status, inverted when normally closed.
*/
`ifndef OUTPUT_TERMINAL_ROUTING_PARAMS_SVH
`define OUTPUT_TERMINAL_ROUTING_PARAMS_SVH

// Word indexes on the bus; byte address is four times the index.
`define IDX_FUNC_BASE     6'h00
`define IDX_POL_BASE      6'h06
`define IDX_METER_BASE    6'h0C
`define IDX_FULL_SCALE    6'h0F
`define IDX_CODE_CTRL     6'h10
`define IDX_LEVELS        6'h11

// Reset values of the selection and polarity registers.
`define RST_OUT11_FUNC    8'h01
`define RST_OUT12_FUNC    8'h00
`define RST_OUT13_FUNC    8'h03
`define RST_OUT14_FUNC    8'h07
`define RST_OUT15_FUNC    8'h08
`define RST_RELAY_FUNC    8'h05
`define RST_METER_SEL     8'h00
`define POL_OPEN          8'h00
`define POL_CLOSED        8'h01
`define RST_TERM_POL      8'h00
`define RST_RELAY_POL     8'h01

// Full scale in hundredths of rated current.
`define FS_MIN            16'h0014
`define FS_MAX            16'h00C8
`define RST_FULL_SCALE    16'h0064

// Analog source count and status vector size.
`define ANALOG_FUNCS      8'h0C
`define STATUS_FUNCS      8'h40

// Fault code control bits.
`define CODE_EN_BIT       0
`define CODE_WIDE_BIT     1

// Pulse timing.
`define CLK_HZ            25000000
`define MON_FREQ_HZ       1440
`define MON_PERIOD_CYC    (`CLK_HZ / `MON_FREQ_HZ)

`endif

// file: rtl/output_terminal_routing_pkg.sv
/*
  Types for the output terminal router.
  Assumes the params header is included by the module that uses these types.
*/
package output_terminal_routing_pkg;

  // Complete register and output state of the router.
  typedef struct packed {
    logic [5:0][7:0]  func_sel;
    logic [5:0][7:0]  pol;
    logic [2:0][7:0]  meter_sel;
    logic [15:0]      full_scale;
    logic [1:0]       code_ctrl;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [4:0]       term_oe;
    logic             relay_on;
    logic [2:0][15:0] meter;
    logic [14:0]      mon_cnt;
    logic             mon_pulse;
  } state_t;

  // Analog sources offered to the meters.
  typedef logic [11:0][15:0] analog_bus_t;

endpackage : output_terminal_routing_pkg

// file: rtl/output_terminal_routing.sv
/*
  Output terminal router: five open-collector logic terminals, one relay,
  three analog meters and a digital current monitor pulse, set over APB.
  Assumes status, fault code, analog sources and current come from logic on
  core_clk, so none of them is synchronised here.
*/
// Decided for this implementation: the register addresses and the APB interface to the registers.
`include "output_terminal_routing_params.svh"
`timescale 1ns/1ns
`default_nettype none

module output_terminal_routing #(
  parameter int MON_PERIOD = `MON_PERIOD_CYC
) (
  // Clock and reset.
  input  wire logic                                      core_clk,
  input  wire logic                                      rst_n,
  // APB slave.
  input  wire logic                                      psel,
  input  wire logic                                      penable,
  input  wire logic                                      pwrite,
  input  wire logic [7:0]                                paddr,
  input  wire logic [31:0]                               pwdata,
  output logic [31:0]                                    prdata,
  output logic                                           pready,
  output logic                                           pslverr,
  // Internal status, indexed by function code.
  input  wire logic [63:0]                               status_func,
  input  wire logic [3:0]                                fault_code_bit,
  input  wire output_terminal_routing_pkg::analog_bus_t  analog_src,
  input  wire logic [15:0]                               motor_current,
  // Open-collector terminals 11 to 15 and the relay.
  output logic [4:0]                                     term_out,
  output logic [4:0]                                     term_oe,
  output logic                                           relay_on,
  // Meter outputs.
  output logic [15:0]                                    freq_meter_out,
  output logic [15:0]                                    voltage_meter_out,
  output logic [15:0]                                    current_loop_out,
  output logic                                           current_pulse
);

  output_terminal_routing_pkg::state_t st;
  output_terminal_routing_pkg::state_t next_st;

  logic [5:0]  idx;
  logic        setup;
  logic        wr_en;
  logic [5:0]  level;
  logic [31:0] mon_lhs;
  logic [31:0] mon_rhs;

  // Status bit picked by an 8-bit code; codes past the vector read inactive.
  function automatic logic pick(input logic [7:0] code,
                                input logic [63:0] vec);
    logic r;
    r = 1'b0;
    if (code < `STATUS_FUNCS)
    begin
      r = vec[code[5:0]];
    end
    return r;
  endfunction : pick

  assign idx   = paddr[7:2];
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & st.pready;

  // Selected levels before polarity; fault code bits displace the selection.
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      level[i] = pick(st.func_sel[i], status_func);  // RL1 RL2 RL3 RL4 RL5
    end
    if (st.code_ctrl[`CODE_EN_BIT])
    begin
      level[2:0] = fault_code_bit[2:0];  // RL7
      if (st.code_ctrl[`CODE_WIDE_BIT])
      begin
        level[3] = fault_code_bit[3];  // RL7
      end
    end
  end

  // Pulse duty: high while cnt/period is below current/full scale.
  assign mon_lhs = {2'h0, st.mon_cnt, 15'h0000} >> 15;
  assign mon_rhs = 32'(motor_current) * 32'(MON_PERIOD);

  // Next state: bus access, routing and the monitor pulse.
  always_comb
  begin
    next_st = st;
    next_st.pready  = setup;
    next_st.pslverr = 1'b0;
    if (setup)
    begin
      next_st.prdata = 32'h00000000;
      if (idx < `IDX_POL_BASE)
      begin
        next_st.prdata[7:0] = st.func_sel[3'(idx)];
      end
      else if (idx < `IDX_METER_BASE)
      begin
        next_st.prdata[7:0] = st.pol[3'(idx - `IDX_POL_BASE)];
      end
      else if (idx < `IDX_FULL_SCALE)
      begin
        next_st.prdata[7:0] = st.meter_sel[2'(idx - `IDX_METER_BASE)];
      end
      else if (idx == `IDX_FULL_SCALE)
      begin
        next_st.prdata[15:0] = st.full_scale;
        // Out-of-range full scale is refused with an error.
        next_st.pslverr = pwrite && (pwdata[15:0] < `FS_MIN ||
                                     pwdata[15:0] > `FS_MAX);  // RL11
      end
      else if (idx == `IDX_CODE_CTRL)
      begin
        next_st.prdata[1:0] = st.code_ctrl;
      end
      else if (idx == `IDX_LEVELS)
      begin
        next_st.prdata[5:0] = {st.relay_on, st.term_oe};
        next_st.pslverr     = pwrite;
      end
      else
      begin
        next_st.pslverr = 1'b1;
      end
    end
    if (wr_en && !st.pslverr)
    begin
      if (idx < `IDX_POL_BASE)
      begin
        next_st.func_sel[3'(idx)] = pwdata[7:0];
      end
      else if (idx < `IDX_METER_BASE)
      begin
        next_st.pol[3'(idx - `IDX_POL_BASE)] = pwdata[7:0];  // RL8
      end
      else if (idx < `IDX_FULL_SCALE)
      begin
        next_st.meter_sel[2'(idx - `IDX_METER_BASE)] = pwdata[7:0];
      end
      else if (idx == `IDX_FULL_SCALE)
      begin
        next_st.full_scale = pwdata[15:0];  // RL11
      end
      else if (idx == `IDX_CODE_CTRL)
      begin
        next_st.code_ctrl = pwdata[1:0];
      end
    end
    // Polarity 01 inverts; open-collector conducts while the level is on.
    for (int i = 0; i < 5; i++)
    begin
      next_st.term_oe[i] = level[i] ^ (st.pol[i] == `POL_CLOSED);  // RL12
    end
    next_st.relay_on = level[5] ^ (st.pol[5] == `POL_CLOSED);  // RL8
    // Meter codes past the source list give zero rather than a stale value.
    for (int m = 0; m < 3; m++)
    begin
      next_st.meter[m] = 16'h0000;
      if (st.meter_sel[m] < `ANALOG_FUNCS)
      begin
        next_st.meter[m] = analog_src[4'(st.meter_sel[m])];  // RL6
      end
    end
    // Period counter for the 1.44 kHz pulse.
    if (st.mon_cnt >= 15'(MON_PERIOD - 1))
    begin
      next_st.mon_cnt = 15'h0000;  // RL11
    end
    else
    begin
      next_st.mon_cnt = st.mon_cnt + 15'h0001;
    end
    next_st.mon_pulse = (mon_lhs * 32'(st.full_scale)) < mon_rhs;  // RL11
  end

  // State register; reset loads the documented defaults.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.func_sel <= {`RST_RELAY_FUNC, `RST_OUT15_FUNC, `RST_OUT14_FUNC,
                      `RST_OUT13_FUNC, `RST_OUT12_FUNC, `RST_OUT11_FUNC};
      st.pol <= {`RST_RELAY_POL, {5{`RST_TERM_POL}}};  // RL9 RL10
      st.meter_sel <= {3{`RST_METER_SEL}};  // RL6
      st.full_scale <= `RST_FULL_SCALE;  // RL11
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register, term_out held at zero; terminals only sink current.
  assign prdata            = st.prdata;
  assign pready            = st.pready;
  assign pslverr           = st.pslverr;
  assign term_out          = 5'h00;
  assign term_oe           = st.term_oe;
  assign relay_on          = st.relay_on;
  assign freq_meter_out    = st.meter[0];
  assign voltage_meter_out = st.meter[1];
  assign current_loop_out  = st.meter[2];
  assign current_pulse     = st.mon_pulse;

  // Checks on routing, polarity and register behaviour.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_plain;
    !st.code_ctrl[`CODE_EN_BIT];
  endsequence

  sequence s_code_wide;
    st.code_ctrl == 2'h3;
  endsequence

  a_out11_route: assert property (s_plain |=> term_oe[0] ==  // RL1
    ($past(pick(st.func_sel[0], status_func)) ^ $past(st.pol[0][0])))
    else $error("Terminal 11 level does not follow its selection.");

  a_out12_route: assert property (s_plain |=> term_oe[1] ==  // RL2
    ($past(pick(st.func_sel[1], status_func)) ^ $past(st.pol[1][0])))
    else $error("Terminal 12 level does not follow its selection.");

  a_out13_route: assert property ((s_plain and st.pol[2] == `POL_OPEN)  // RL3
    |=> term_oe[2] == $past(pick(st.func_sel[2], status_func)))
    else $error("Terminal 13 level does not follow its selection.");

  a_out14_route: assert property ((s_plain and st.pol[3] == `POL_CLOSED)  // RL4
    |=> term_oe[3] != $past(pick(st.func_sel[3], status_func)))
    else $error("Terminal 14 level is not inverted when closed.");

  a_relay_route: assert property (1'b1 |=> relay_on ==  // RL5
    ($past(pick(st.func_sel[5], status_func)) ^ $past(st.pol[5][0])))
    else $error("Relay does not follow its selection and polarity.");

  a_meter_select: assert property (st.meter_sel[0] < `ANALOG_FUNCS  // RL6
    |=> freq_meter_out == $past(analog_src[4'(st.meter_sel[0])]))
    else $error("Frequency meter does not carry its selected source.");

  a_fault_code: assert property (s_code_wide |=>  // RL7
    term_oe[3:0] == ($past(fault_code_bit) ^
      {$past(st.pol[3][0]), $past(st.pol[2][0]),
       $past(st.pol[1][0]), $past(st.pol[0][0])}))
    else $error("Fault code bits are not driven on terminals 11-14.");

  a_pol_cause: assert property ($changed(st.pol)  // RL8 RL9 RL10
    |-> $past(wr_en) && $past(idx) >= `IDX_POL_BASE &&
        $past(idx) < `IDX_METER_BASE)
    else $error("Polarity changed without a bus write.");

  a_scale_range: assert property (st.full_scale >= `FS_MIN &&  // RL11
    st.full_scale <= `FS_MAX)
    else $error("Full scale left the allowed range.");

  a_period_wrap: assert property (st.mon_cnt == 15'(MON_PERIOD - 1)  // RL11
    |=> st.mon_cnt == 15'h0000)
    else $error("Monitor period counter did not wrap.");

  a_level_track: assert property ($changed(status_func) && s_plain  // RL12
    ##1 s_plain |=> term_oe[4] ==
      ($past(pick(st.func_sel[4], status_func), 2) ^ $past(st.pol[4][0], 2))
      || $past(st.func_sel[4]) != $past(st.func_sel[4], 2))
    else $error("Terminal 15 did not track its status change.");

endmodule : output_terminal_routing

`default_nettype wire

// file: verification/terminal_load.sv
/*
  Far-side load: pull-up resistors on the open-collector terminals and the
  relay contact seen by the controller inputs.
  Assumes term_oe, term_out and relay_on come straight from the router.
*/
`timescale 1ns/1ns
`default_nettype none

module terminal_load (
  // Router side.
  input  wire logic [4:0] term_oe,
  input  wire logic [4:0] term_out,
  input  wire logic       relay_on,
  // Levels seen by the far side.
  output logic      [4:0] pin_level,
  output logic            contact_closed
);
  // A released pin goes to the pull-up level, never to the last driven one.
  always_comb
  begin
    for (int i = 0; i < 5; i++)
      pin_level[i] = term_oe[i] ? term_out[i] : 1'b1;
    contact_closed = relay_on;
  end
endmodule : terminal_load

`default_nettype wire

// file: verification/output_terminal_routing_tb.sv
/*
  Self-checking bench for the output terminal router: APB master, random
  status stimulus and a reference model of routing, polarity and pulse.
  Assumes the router package and the terminal load model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module output_terminal_routing_tb;
  logic        core_clk, rst_n, psel, penable, pwrite, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, lf;
  logic        pready, pslverr, relay_on, current_pulse, contact_closed;
  logic [63:0] status_func;
  logic [3:0]  fault_code_bit;
  logic [15:0] motor_current, freq_meter_out, voltage_meter_out;
  logic [15:0] current_loop_out;
  logic [4:0]  term_out, term_oe, pin_level;
  output_terminal_routing_pkg::analog_bus_t analog_src;
  int          err_total = 0, checked = 0, cyc = 0, ctrl = 0;
  int          regs[16] = '{1, 0, 3, 7, 8, 5, 0, 0, 0, 0, 0, 1, 0, 0, 0, 100};
  int          fs_tab[4] = '{19, 20, 201, 200};

  // Small pulse period keeps a full duty window to 16 cycles.
  output_terminal_routing #(.MON_PERIOD(16)) u_output_terminal_routing (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .status_func, .fault_code_bit, .analog_src,
    .motor_current, .term_out, .term_oe, .relay_on, .freq_meter_out,
    .voltage_meter_out, .current_loop_out, .current_pulse);
  terminal_load u_terminal_load (
    .term_oe, .term_out, .relay_on, .pin_level, .contact_closed);

  // Free-running 25 MHz clock.
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Reference model: bit 5 is the relay, bits 0..4 terminals 11..15.
  function automatic logic [5:0] exp_levels();
    logic lvl;
    for (int i = 0; i < 6; i++)
    begin
      lvl = regs[i] < 64 ? status_func[regs[i]] : 1'b0;
      if (ctrl[0] && (i < 3 || (i == 3 && ctrl[1])))
        lvl = fault_code_bit[i];
      exp_levels[i] = lvl ^ (regs[6 + i] == 1);
    end
  endfunction : exp_levels

  function automatic logic [15:0] meter(input int k);
    return regs[12 + k] < 12 ? analog_src[regs[12 + k]] : 16'h0000;
  endfunction : meter

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s got %h", $time, what, seen);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high, for at most 10 cycles.
  task automatic apb(input logic w, input int idx, input int wd);
    int n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= 8'(idx * 4);
    pwdata <= 32'(wd);
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 10);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(pready), 32'h1, "no answer");
  endtask : apb

  // New random status, fault code and analog sources at a clock edge.
  task automatic stim();
    lf = lfsr_next(lf);
    status_func <= {lf, ~lf};
    fault_code_bit <= lf[7:4];
    for (int k = 0; k < 12; k++)
      analog_src[k] <= 16'(lf * (k + 3));
  endtask : stim

  task automatic cmp_out();
    logic [5:0] e;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    e = exp_levels();
    chk(32'({relay_on, term_oe}), 32'(e), "levels");
    chk(32'({contact_closed, pin_level}), 32'({e[5], ~e[4:0]}), "pins");
    chk(32'(term_out), 32'h0, "term_out");
    chk(32'(freq_meter_out), 32'(meter(0)), "meter a");
    chk(32'(voltage_meter_out), 32'(meter(1)), "meter b");
    chk(32'(current_loop_out), 32'(meter(2)), "meter c");
  endtask : cmp_out

  // Counts pulse highs over one full period of 16 cycles.
  task automatic pulse_check(input int cur);
    int want = 0;
    int got = 0;
    motor_current <= 16'(cur);
    for (int c = 0; c < 16; c++)
      want += int'(c * regs[15] < cur * 16);
    repeat (4) @(posedge core_clk);
    repeat (16)
    begin
      @(negedge core_clk);
      got += int'(current_pulse);
    end
    chk(32'(got), 32'(want), "pulse duty");
  endtask : pulse_check

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // Main sequence: defaults, refusals, random rounds, full scale and pulse.
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {status_func, fault_code_bit, analog_src, motor_current} = '0;
    lf = 32'h6EEA;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b0, i, 0);
      chk(rd, 32'(regs[i]), "reset value");
    end
    stim();
    cmp_out();
    foreach (fs_tab[j])
    begin
      apb(1'b1, 17 + j, 0);
      chk(32'(er), 32'h1, "refused write");
    end
    for (int r = 0; r < 8; r++)
    begin
      for (int i = 0; i < 15; i++)
      begin
        lf = lfsr_next(lf);
        regs[i] = i >= 12 ? int'(lf[3:0]) : i >= 6 ? int'(lf[0]) :
                  r < 6 ? int'(lf[5:0]) : int'(lf[7:0]);
        apb(1'b1, i, regs[i]);
        apb(1'b0, i, 0);
        chk(rd, 32'(regs[i]), "readback");
      end
      ctrl = r & 3;
      apb(1'b1, 16, ctrl);
      stim();
      cmp_out();
      apb(1'b0, 17, 0);
      chk(rd, 32'(exp_levels()), "levels reg");
    end
    foreach (fs_tab[j])
    begin
      apb(1'b1, 15, fs_tab[j]);
      chk(32'(er), 32'(fs_tab[j] < 20 || fs_tab[j] > 200), "range");
      if (er === 1'b0)
        regs[15] = fs_tab[j];
      apb(1'b0, 15, 0);
      chk(rd, 32'(regs[15]), "full scale");
      pulse_check(regs[15] * 3 / 8);
      pulse_check(regs[15]);
    end
    close_out();
  end
endmodule : output_terminal_routing_tb

`default_nettype wire
